// *** rtl/spc_standby_pin_ctrl.sv ***
// standby pin state control: port pin drive, pull-ups and hardware standby sequencing
//
// Overview of operation
// - held input pin floats, pull-up per control bit
// - held output pin keeps its prior level in sleep; in software standby it takes its port data register level
// - direction bit sets pin mode; peripherals override
// - software standby resets peripherals, pins revert
`timescale 1ns/1ps
`default_nettype none
module spc_standby_pin_ctrl
  import spc_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // avalon-mm slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // external control pins
  input wire logic system_init_n_i,
  input wire logic standby_pin_n_i,
  // on-chip peripheral claim of pins
  input wire logic [spc_pkg::SPC_PORT_W-1:0] periph_en_i,
  input wire logic [spc_pkg::SPC_PORT_W-1:0] periph_oe_i,
  input wire logic [spc_pkg::SPC_PORT_W-1:0] periph_out_i,
  // port pins
  input wire logic [spc_pkg::SPC_PORT_W-1:0] port_pin_i,
  output logic [spc_pkg::SPC_PORT_W-1:0] port_pin_o,
  output logic [spc_pkg::SPC_PORT_W-1:0] port_pin_oe_o,
  output logic [spc_pkg::SPC_PORT_W-1:0] pullup_en_o,
  // status
  output logic periph_init_o,
  output logic ram_retained_o,
  output logic [1:0] power_state_o
);
  logic init_n_s, standby_pin_n_n_s, init_n_d1_q, standby_pin_n_n_d1_q;
  logic [SPC_PORT_W-1:0] pin_s;
  logic [SPC_PORT_W-1:0] dir_q, data_q, pullup_q;
  logic onchip_ram_enable_q, swstby_req_q, sleep_req_q, seq_err_q, ram_ok_q;
  logic onchip_ram_enable_hold_q;
  logic [SPC_CNT_W-1:0] init_lead_q;
  logic [SPC_CNT_W-1:0] exit_lead_q;
  spc_state_e state_q;
  logic [SPC_PORT_W-1:0] hold_out_q, hold_oe_q;
  logic req_q;
  logic wake_pin_q;

  spc_sync2 #(.W(2), .RST_VAL(2'b11)) u_sync_ctl (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .async_i({system_init_n_i, standby_pin_n_i}),
    .sync_o({init_n_s, standby_pin_n_n_s})
  );
  spc_sync2 #(.W(SPC_PORT_W), .RST_VAL('0)) u_sync_pin (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .async_i(port_pin_i),
    .sync_o(pin_s)
  );

  function automatic logic [31:0] spc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // bus: one wait cycle per access, so every access completes on the second edge
  logic acc;
  logic wr_go, rd_go;
  assign acc = avs_read_i | avs_write_i;
  assign wr_go = avs_write_i & req_q;
  assign rd_go = avs_read_i & ~req_q;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      req_q <= 1'b0;
      avs_waitrequest_o <= 1'b1;
    end else begin
      req_q <= acc & ~req_q;
      avs_waitrequest_o <= ~(acc & ~req_q);
    end
  end

  logic [31:0] sys_rd;
  always_comb begin
    sys_rd = '0;
    sys_rd[SPC_SYS_ONCHIP_RAM_ENABLE_BIT] = onchip_ram_enable_q;
    sys_rd[SPC_SYS_SWSTBY_BIT] = swstby_req_q;
    sys_rd[SPC_SYS_SLEEP_BIT] = sleep_req_q;
    sys_rd[SPC_SYS_STATE_LSB +: 2] = state_q;
    sys_rd[SPC_SYS_SEQERR_BIT] = seq_err_q;
    sys_rd[SPC_SYS_RAMOK_BIT] = ram_ok_q;
  end

  // read data latched while waitrequest is high, stands at the completing edge
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      avs_readdata_o <= '0;
    end else if (rd_go) begin
      case (avs_address_i)
        SPC_OFS_DIR: avs_readdata_o <= {24'h000000, dir_q};
        SPC_OFS_DATA: avs_readdata_o <= {24'h000000, (dir_q & data_q) | (~dir_q & pin_s)};
        SPC_OFS_PULLUP: avs_readdata_o <= {24'h000000, pullup_q};
        SPC_OFS_SYSCTL: avs_readdata_o <= sys_rd;
        default: avs_readdata_o <= '0;
      endcase
    end
  end

  // port registers; reset by system init pin as well as by sys_rst_i
  logic [31:0] wv;
  always_comb begin
    wv = '0;
    case (avs_address_i)
      SPC_OFS_DIR: wv = spc_merge({24'h000000, dir_q}, avs_writedata_i, avs_byteenable_i);
      SPC_OFS_DATA: wv = spc_merge({24'h000000, data_q}, avs_writedata_i, avs_byteenable_i);
      SPC_OFS_PULLUP: wv = spc_merge({24'h000000, pullup_q}, avs_writedata_i, avs_byteenable_i);
      SPC_OFS_SYSCTL: wv = spc_merge(sys_rd, avs_writedata_i, avs_byteenable_i);
      default: wv = '0;
    endcase
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dir_q <= SPC_RST_DIR;
      data_q <= SPC_RST_DATA;
      pullup_q <= SPC_RST_PULLUP;
      onchip_ram_enable_q <= SPC_RST_ONCHIP_RAM_ENABLE;
    end else if (!init_n_s) begin
      dir_q <= SPC_RST_DIR;
      data_q <= SPC_RST_DATA;
      pullup_q <= SPC_RST_PULLUP;
      onchip_ram_enable_q <= SPC_RST_ONCHIP_RAM_ENABLE;
    end else if (wr_go) begin
      case (avs_address_i)
        SPC_OFS_DIR: dir_q <= wv[SPC_PORT_W-1:0];
        SPC_OFS_DATA: data_q <= wv[SPC_PORT_W-1:0];
        SPC_OFS_PULLUP: pullup_q <= wv[SPC_PORT_W-1:0];
        SPC_OFS_SYSCTL: onchip_ram_enable_q <= wv[SPC_SYS_ONCHIP_RAM_ENABLE_BIT];
        default: ;
      endcase
    end
  end

  // ram enable as software left it before init fell; init forces the live bit back to 1,
  // so the entry verdict must not read the live bit while init is low
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      onchip_ram_enable_hold_q <= SPC_RST_ONCHIP_RAM_ENABLE;
    end else if (init_n_s) begin
      onchip_ram_enable_hold_q <= onchip_ram_enable_q;
    end
  end

  // low-power requests are one-shot: cleared by the wake-up
  logic wake;
  assign wake = wake_pin_q;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      swstby_req_q <= 1'b0;
      sleep_req_q <= 1'b0;
    end else if (!init_n_s || wake) begin
      swstby_req_q <= 1'b0;
      sleep_req_q <= 1'b0;
    end else if (wr_go && avs_address_i == SPC_OFS_SYSCTL) begin
      swstby_req_q <= wv[SPC_SYS_SWSTBY_BIT];
      sleep_req_q <= wv[SPC_SYS_SLEEP_BIT] & ~wv[SPC_SYS_SWSTBY_BIT];
    end
  end

  // an input pin at a level other than its data bit wakes from sleep or software standby
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wake_pin_q <= 1'b0;
    end else begin
      wake_pin_q <= (state_q == SPC_ST_SLEEP || state_q == SPC_ST_SWSTBY) && |(~hold_oe_q & (pin_s ^ data_q));
    end
  end

  // edge tracking of the control pins
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      init_n_d1_q <= 1'b1;
      standby_pin_n_n_d1_q <= 1'b1;
    end else begin
      init_n_d1_q <= init_n_s;
      standby_pin_n_n_d1_q <= standby_pin_n_n_s;
    end
  end

  // counts clocks init has been low; saturates
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      init_lead_q <= '0;
    end else if (init_n_s) begin
      init_lead_q <= '0;
    end else if (init_lead_q != '1) begin
      init_lead_q <= init_lead_q + 1'b1;
    end
  end

  // counts clocks init has been low while standby still asserted, for exit check
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      exit_lead_q <= '0;
    end else if (init_n_s || standby_pin_n_n_s) begin
      exit_lead_q <= '0;
    end else if (exit_lead_q != '1) begin
      exit_lead_q <= exit_lead_q + 1'b1;
    end
  end

  // ram retention verdict on standby entry; error flag sticky until written 1 to clear
  logic standby_pin_n_fall, standby_pin_n_rise, entry_ok, exit_bad;
  assign standby_pin_n_fall = standby_pin_n_n_d1_q & ~standby_pin_n_n_s;
  assign standby_pin_n_rise = ~standby_pin_n_n_d1_q & standby_pin_n_n_s;
  assign entry_ok = (init_n_s ? onchip_ram_enable_q : onchip_ram_enable_hold_q)
                    || (!init_n_s && init_lead_q >= SPC_CNT_W'(SPC_ENTRY_LEAD_CYC));
  assign exit_bad = standby_pin_n_rise && (init_n_s || exit_lead_q < SPC_CNT_W'(SPC_EXIT_LEAD_CYC));
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ram_ok_q <= 1'b1;
      seq_err_q <= 1'b0;
    end else begin
      if (standby_pin_n_fall) begin
        ram_ok_q <= entry_ok;
      end
      // with ram enable clear, init must have been low SPC_ENTRY_LEAD_CYC clocks when standby falls, else treated as bad entry
      if (standby_pin_n_fall && !entry_ok) begin
        seq_err_q <= 1'b1;
      end else if (exit_bad) begin
        seq_err_q <= 1'b1;
      end else if (wr_go && avs_address_i == SPC_OFS_SYSCTL && avs_byteenable_i[1]
                   && avs_writedata_i[SPC_SYS_SEQERR_BIT]) begin
        seq_err_q <= 1'b0;
      end
    end
  end

  // power state
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= SPC_ST_RUN;
    end else begin
      case (state_q)
        SPC_ST_RUN: begin
          if (!standby_pin_n_n_s) begin
            state_q <= SPC_ST_HWSTBY;
          end else if (swstby_req_q) begin
            state_q <= SPC_ST_SWSTBY;
          end else if (sleep_req_q) begin
            state_q <= SPC_ST_SLEEP;
          end
        end
        SPC_ST_SLEEP, SPC_ST_SWSTBY: begin
          if (!standby_pin_n_n_s) begin
            state_q <= SPC_ST_HWSTBY;
          end else if (!init_n_s || wake) begin
            state_q <= SPC_ST_RUN;
          end
        end
        SPC_ST_HWSTBY: begin
          // leaving goes through reset: init is low here by the exit ordering
          if (standby_pin_n_n_s) begin
            state_q <= SPC_ST_RUN;
          end
        end
        default: state_q <= SPC_ST_RUN;
      endcase
    end
  end

  // live pin function in run state
  logic [SPC_PORT_W-1:0] run_oe, run_out, sw_oe, sw_out;
  assign run_oe = (periph_en_i & periph_oe_i) | (~periph_en_i & dir_q);
  assign run_out = (periph_en_i & periph_out_i) | (~periph_en_i & data_q);
  assign sw_oe = dir_q;
  assign sw_out = data_q;

  // snapshot taken as a low-power state is entered
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hold_out_q <= '0;
      hold_oe_q <= '0;
    end else if (state_q == SPC_ST_RUN) begin
      hold_out_q <= swstby_req_q ? sw_out : run_out;
      hold_oe_q <= swstby_req_q ? sw_oe : run_oe;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      port_pin_o <= '0;
      port_pin_oe_o <= '0;
      pullup_en_o <= '0;
      periph_init_o <= 1'b0;
    end else begin
      periph_init_o <= (state_q == SPC_ST_SWSTBY) || !init_n_s;
      case (state_q)
        SPC_ST_HWSTBY: begin
          port_pin_o <= '0;
          port_pin_oe_o <= '0;
          pullup_en_o <= '0;
        end
        SPC_ST_SLEEP, SPC_ST_SWSTBY: begin
          port_pin_o <= hold_out_q;
          port_pin_oe_o <= hold_oe_q;
          pullup_en_o <= ~hold_oe_q & pullup_q;
        end
        default: begin
          port_pin_o <= run_out;
          port_pin_oe_o <= run_oe;
          pullup_en_o <= ~run_oe & pullup_q;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ram_retained_o <= 1'b1;
      power_state_o <= 2'h0;
    end else begin
      ram_retained_o <= ram_ok_q;
      power_state_o <= state_q;
    end
  end

  // checks
  property p_hw_float;
    @(posedge clock_i) disable iff (sys_rst_i)
    state_q == SPC_ST_HWSTBY |=> port_pin_oe_o == '0 && pullup_en_o == '0;
  endproperty
  a_hw_float: assert property (p_hw_float) else $error("pins driven in hardware standby");

  property p_hold_level;
    @(posedge clock_i) disable iff (sys_rst_i)
    state_q == SPC_ST_SLEEP && $past(state_q) == SPC_ST_SLEEP |=> $stable(port_pin_o) && $stable(port_pin_oe_o);
  endproperty
  a_hold_level: assert property (p_hold_level) else $error("held output changed");

  property p_pullup_held;
    @(posedge clock_i) disable iff (sys_rst_i)
    state_q == SPC_ST_SWSTBY |=> pullup_en_o == (~port_pin_oe_o & pullup_q);
  endproperty
  a_pullup_held: assert property (p_pullup_held) else $error("held pull-up wrong");

  property p_dir_run;
    @(posedge clock_i) disable iff (sys_rst_i)
    state_q == SPC_ST_RUN && periph_en_i == '0 |=> port_pin_oe_o == $past(dir_q);
  endproperty
  a_dir_run: assert property (p_dir_run) else $error("pin direction mismatch");

  property p_swstby_revert;
    @(posedge clock_i) disable iff (sys_rst_i)
    state_q == SPC_ST_RUN && swstby_req_q && standby_pin_n_n_s ##1 state_q == SPC_ST_SWSTBY |=> port_pin_oe_o == $past(dir_q, 2)
      && periph_init_o;
  endproperty
  a_swstby_revert: assert property (p_swstby_revert) else $error("pins not reverted in software standby");
endmodule
`default_nettype wire

// *** inc/spc_pkg.sv ***
// package: register map, field positions, reset values and timing for the standby pin control block
package spc_pkg;
  localparam int unsigned SPC_PORT_W = 8;
  localparam int unsigned SPC_CLK_MHZ = 200;
  // register word offsets (byte addresses)
  localparam logic [3:0] SPC_OFS_DIR = 4'h0;
  localparam logic [3:0] SPC_OFS_DATA = 4'h4;
  localparam logic [3:0] SPC_OFS_PULLUP = 4'h8;
  localparam logic [3:0] SPC_OFS_SYSCTL = 4'hc;
  // system control fields
  localparam int unsigned SPC_SYS_ONCHIP_RAM_ENABLE_BIT = 0;
  localparam int unsigned SPC_SYS_SWSTBY_BIT = 1;
  localparam int unsigned SPC_SYS_SLEEP_BIT = 2;
  localparam int unsigned SPC_SYS_STATE_LSB = 4;
  localparam int unsigned SPC_SYS_SEQERR_BIT = 8;
  localparam int unsigned SPC_SYS_RAMOK_BIT = 9;
  localparam int unsigned SPC_SYS_W = 10;
  // reset values
  localparam logic [SPC_PORT_W-1:0] SPC_RST_DIR = 8'h00;
  localparam logic [SPC_PORT_W-1:0] SPC_RST_DATA = 8'h00;
  localparam logic [SPC_PORT_W-1:0] SPC_RST_PULLUP = 8'h00;
  localparam logic SPC_RST_ONCHIP_RAM_ENABLE = 1'b1;
  // entry ordering: init low at least this many clocks before standby low
  localparam int unsigned SPC_ENTRY_LEAD_CYC = 10;
  // exit lead time: init low about this long before standby high
  localparam int unsigned SPC_EXIT_LEAD_NS = 100;
  localparam int unsigned SPC_EXIT_LEAD_CYC = (SPC_EXIT_LEAD_NS * SPC_CLK_MHZ) / 1000;
  localparam int unsigned SPC_CNT_W = 8;
  typedef enum logic [1:0] {
    SPC_ST_RUN,
    SPC_ST_SLEEP,
    SPC_ST_SWSTBY,
    SPC_ST_HWSTBY
  } spc_state_e;
endpackage

// *** rtl/spc_sync2.sv ***
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`default_nettype none
module spc_sync2 #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // async in, synced out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_q <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// *** sim/spc_host_model.sv ***
// partner: external system controller sequencing the init and standby pins
`timescale 1ns/1ps
`default_nettype none
module spc_host_model (
  // clock
  input wire logic clock_i,
  // control pins
  output logic init_n_o,
  output logic standby_pin_n_n_o
);
  initial begin
    init_n_o = 1'b1;
    standby_pin_n_n_o = 1'b1;
  end

  // lead 0 skips the init pulse, only safe for retention with ram enable set
  task automatic enter(input int lead);
    if (lead > 0) begin
      init_n_o <= 1'b0;
      repeat (lead) @(posedge clock_i);
    end
    standby_pin_n_n_o <= 1'b0;
    @(posedge clock_i);
    init_n_o <= 1'b1;
  endtask

  // init stays low a few clocks past standby release so the reset sequence runs
  task automatic leave(input int lead);
    init_n_o <= 1'b0;
    repeat (lead) @(posedge clock_i);
    standby_pin_n_n_o <= 1'b1;
    repeat (4) @(posedge clock_i);
    init_n_o <= 1'b1;
    repeat (6) @(posedge clock_i);
  endtask
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// testbench: register access, held pin states and hardware standby sequencing
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import spc_pkg::*;
  localparam logic [31:0] ONCHIP_RAM_ENABLE = 32'h1 << SPC_SYS_ONCHIP_RAM_ENABLE_BIT;
  localparam logic [31:0] RAMOK = 32'h1 << SPC_SYS_RAMOK_BIT;
  localparam logic [31:0] SEQERR = 32'h1 << SPC_SYS_SEQERR_BIT;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdat;
  logic [31:0] rdata;
  logic wreq;
  logic [7:0] pen = 8'h00;
  logic [7:0] poe = 8'h00;
  logic [7:0] pout = 8'h00;
  logic [7:0] pin = 8'h00;
  logic [7:0] pin_o;
  logic [7:0] oe_o;
  logic [7:0] pu_o;
  logic pinit;
  logic retained;
  logic [1:0] pstate;
  logic init_n;
  logic standby_pin_n_n;
  int errors = 0;
  int compares = 0;

  always #2.5 clock_i = ~clock_i;

  spc_host_model spc_host_model_inst (
    .clock_i(clock_i),
    .init_n_o(init_n),
    .standby_pin_n_n_o(standby_pin_n_n)
  );

  spc_standby_pin_ctrl spc_standby_pin_ctrl_inst (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .avs_address_i(adr),
    .avs_read_i(rd),
    .avs_write_i(wr),
    .avs_writedata_i(wdat),
    .avs_byteenable_i(be),
    .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq),
    .system_init_n_i(init_n),
    .standby_pin_n_i(standby_pin_n_n),
    .periph_en_i(pen),
    .periph_oe_i(poe),
    .periph_out_i(pout),
    .port_pin_i(pin),
    .port_pin_o(pin_o),
    .port_pin_oe_o(oe_o),
    .pullup_en_o(pu_o),
    .periph_init_o(pinit),
    .ram_retained_o(retained),
    .power_state_o(pstate)
  );

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end
    else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // request held until waitrequest is sampled low; readdata taken at that edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    adr <= a;
    wr <= w;
    rd <= ~w;
    wdat <= d;
    do begin
      @(posedge clock_i);
    end while (wreq !== 1'b0);
    rdata = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rreg(input logic [3:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(what, rdata, exp);
  endtask

  // bounded wait for the state, then a few clocks for the pins to settle
  task automatic waitst(input logic [1:0] s);
    int n;
    n = 0;
    while (pstate !== s && n < 100) begin
      @(posedge clock_i);
      n++;
    end
    repeat (3) @(posedge clock_i);
    chk("power_state", 32'(pstate), 32'(s));
  endtask

  initial begin
    repeat (2000) @(posedge clock_i);
    errors++;
    conclude();
  end

  initial begin
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rreg(SPC_OFS_DIR, 32'h0, "dir");
    rreg(SPC_OFS_PULLUP, 32'h0, "pullup");
    rreg(SPC_OFS_SYSCTL, ONCHIP_RAM_ENABLE | RAMOK, "sysctl");
    rreg(4'h2, 32'h0, "unmapped");
    pin <= 8'h3c;
    pen <= 8'h01;
    poe <= 8'h01;
    pout <= 8'h01;
    wreg(SPC_OFS_DIR, 32'hf0);
    wreg(SPC_OFS_DATA, 32'ha5);
    wreg(SPC_OFS_PULLUP, 32'h3c);
    rreg(SPC_OFS_DATA, 32'hac, "data");
    chk("oe", 32'(oe_o), 32'hf1);
    chk("drive", 32'(pin_o & oe_o), 32'ha1);
    // inputs match data bits so the sleep is not woken at once
    pen <= 8'h00;
    pin <= 8'ha5;
    wreg(SPC_OFS_SYSCTL, ONCHIP_RAM_ENABLE | (32'h1 << SPC_SYS_SLEEP_BIT));
    waitst(SPC_ST_SLEEP);
    chk("sleep oe", 32'(oe_o), 32'hf0);
    chk("sleep drive", 32'(pin_o & oe_o), 32'ha0);
    chk("sleep pullup", 32'(pu_o), 32'h0c);
    pin <= 8'ha4;
    waitst(SPC_ST_RUN);
    pen <= 8'h01;
    poe <= 8'h00;
    pout <= 8'h00;
    wreg(SPC_OFS_DIR, 32'hf1);
    chk("periph drive", 32'(pin_o & oe_o), 32'ha0);
    chk("periph oe", 32'(oe_o), 32'hf0);
    // upper lanes only: the 8-bit direction register must keep its value
    be <= 4'he;
    wreg(SPC_OFS_DIR, 32'h00);
    be <= 4'hf;
    rreg(SPC_OFS_DIR, 32'hf1, "dir lanes");
    wreg(SPC_OFS_SYSCTL, ONCHIP_RAM_ENABLE | (32'h1 << SPC_SYS_SWSTBY_BIT));
    waitst(SPC_ST_SWSTBY);
    chk("periph_init", 32'(pinit), 32'h1);
    chk("swstby drive", 32'(pin_o & oe_o), 32'ha1);
    chk("swstby oe", 32'(oe_o), 32'hf1);
    pin <= 8'ha6;
    waitst(SPC_ST_RUN);
    chk("periph_init", 32'(pinit), 32'h0);
    pen <= 8'h00;
    wreg(SPC_OFS_SYSCTL, 32'h0);
    spc_host_model_inst.enter(12);
    waitst(SPC_ST_HWSTBY);
    chk("hw oe", 32'(oe_o), 32'h0);
    chk("retained", 32'(retained), 32'h1);
    spc_host_model_inst.leave(24);
    waitst(SPC_ST_RUN);
    rreg(SPC_OFS_SYSCTL, ONCHIP_RAM_ENABLE | RAMOK, "sysctl");
    wreg(SPC_OFS_SYSCTL, 32'h0);
    spc_host_model_inst.enter(3);
    waitst(SPC_ST_HWSTBY);
    chk("retained", 32'(retained), 32'h0);
    spc_host_model_inst.leave(24);
    waitst(SPC_ST_RUN);
    rreg(SPC_OFS_SYSCTL, ONCHIP_RAM_ENABLE | SEQERR, "sysctl");
    // clear bit sits in lane 1, so a lane-0 write must leave the error standing
    be <= 4'h1;
    wreg(SPC_OFS_SYSCTL, ONCHIP_RAM_ENABLE | SEQERR);
    be <= 4'hf;
    rreg(SPC_OFS_SYSCTL, ONCHIP_RAM_ENABLE | SEQERR, "sysctl lanes");
    wreg(SPC_OFS_SYSCTL, ONCHIP_RAM_ENABLE | SEQERR);
    rreg(SPC_OFS_SYSCTL, ONCHIP_RAM_ENABLE, "sysctl");
    wreg(SPC_OFS_DIR, 32'hff);
    spc_host_model_inst.enter(0);
    waitst(SPC_ST_HWSTBY);
    chk("hw oe", 32'(oe_o), 32'h0);
    chk("retained", 32'(retained), 32'h1);
    spc_host_model_inst.leave(5);
    waitst(SPC_ST_RUN);
    rreg(SPC_OFS_SYSCTL, ONCHIP_RAM_ENABLE | RAMOK | SEQERR, "sysctl");
    conclude();
  end
endmodule
`default_nettype wire
